/* File: core/tfp_timer_pkg.sv */
// Constants of the timer counter, flag and periodic interrupt block.
// Assumes a byte-wide register port with eight address bits.
package tfp_timer_pkg;

	// ==========================================================
	// Register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_COUNT_HI      = 8'h00;
	localparam logic [7:0] OFS_COUNT_LO      = 8'h01;
	localparam logic [7:0] OFS_ACTION_CTRL   = 8'h02;
	localparam logic [7:0] OFS_CHAN_MASK     = 8'h03;
	localparam logic [7:0] OFS_CHAN_FLAGS    = 8'h04;
	localparam logic [7:0] OFS_MISC_MASK     = 8'h05;
	localparam logic [7:0] OFS_MISC_FLAGS    = 8'h06;
	localparam logic [7:0] OFS_ACC_CTRL      = 8'h07;

	// ==========================================================
	// Field positions
	localparam int CHAN_SHARED_BIT   = 3;
	localparam int MISC_OVF_BIT      = 7;
	localparam int MISC_PERIODIC_BIT = 6;
	localparam int MISC_ACC_OVF_BIT  = 5;
	localparam int MISC_ACC_EDGE_BIT = 4;
	localparam int PRESCALE_LSB      = 0;
	localparam int ACC_SHARED_SEL    = 2;
	localparam int ACC_RATE_LSB      = 0;

	// Implemented bits of the byte-wide registers
	localparam logic [7:0] MISC_MASK_IMPL  = 8'hF3;
	localparam logic [7:0] MISC_FLAG_IMPL  = 8'hF0;
	localparam logic [7:0] ACC_CTRL_IMPL   = 8'h07;

	// ==========================================================
	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0]  REG_RESET   = 8'h00;

	// ==========================================================
	// Timing
	localparam int          PRESCALE_WINDOW_CYCLES = 64;
	localparam int          PERIODIC_BASE_SHIFT    = 13;
	localparam logic [3:0]  PRESCALE_MASK_DIV1     = 4'h0;
	localparam logic [3:0]  PRESCALE_MASK_DIV4     = 4'h3;
	localparam logic [3:0]  PRESCALE_MASK_DIV8     = 4'h7;
	localparam logic [3:0]  PRESCALE_MASK_DIV16    = 4'hF;

endpackage

/* File: core/tfp_timer_core.sv */
// Timer counter core: prescaled free-running count with coherent read,
// compare pin actions, channel and misc flag/mask registers, a prescaler
// written once outside test mode, and the periodic interrupt divider.
// Assumes compare values, capture edges and accumulator events arrive as
// one-cycle pulses or stable words synchronous to CLK_IN.
`timescale 1ns/100ps
`default_nettype none

module tfp_timer_core #(
	parameter int PERIODIC_SHIFT = tfp_timer_pkg::PERIODIC_BASE_SHIFT
) (
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	// Register port
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [7:0]  WR_DATA_IN,
	input  wire logic        WR_STROBE_IN,
	input  wire logic        RD_STROBE_IN,
	output logic      [7:0]  RD_DATA_OUT,
	// Mode
	input  wire logic        TEST_MODE_IN,
	// Compare values of channels one to five
	input  wire logic [15:0] CMP1_VALUE_IN,
	input  wire logic [15:0] CMP2_VALUE_IN,
	input  wire logic [15:0] CMP3_VALUE_IN,
	input  wire logic [15:0] CMP4_VALUE_IN,
	input  wire logic [15:0] CMP5_VALUE_IN,
	// Event pulses from capture and accumulator logic
	input  wire logic [2:0]  CAPTURE_EDGE_IN,
	input  wire logic        CAPTURE4_EDGE_IN,
	input  wire logic        ACC_ROLLOVER_IN,
	input  wire logic        ACC_EDGE_IN,
	// Compare pins, channels two to five in bits 3..0
	output logic      [3:0]  CMP_PIN_OUT,
	output logic      [3:0]  CMP_PIN_CONNECT_OUT,
	// Status toward other logic
	output logic             SHARED_SELECT_OUT,
	output logic             COUNT_TICK_OUT,
	// Interrupt requests
	output logic             CHANNEL_IRQ_OUT,
	output logic             OVERFLOW_IRQ_OUT,
	output logic             PERIODIC_IRQ_OUT,
	output logic             ACC_IRQ_OUT
);

	// ==========================================================
	// Registers
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [3:0]  presc_cnt_q;
	logic        tick_q;
	logic [7:0]  low_latch_q;
	logic        low_latch_valid_q;
	logic [7:0]  action_ctrl_q;
	logic [7:0]  chan_mask_q;
	logic [7:0]  chan_flags_q;
	logic [7:0]  chan_flags_d;
	logic [7:0]  misc_mask_q;
	logic [7:0]  misc_flags_q;
	logic [7:0]  misc_flags_d;
	logic [7:0]  acc_ctrl_q;
	logic        presc_written_q;
	logic [6:0]  cycle_cnt_q;
	logic [15:0] periodic_div_q;
	logic [3:0]  pin_q;
	logic [3:0]  pin_d;
	logic [7:0]  rd_data_q;

	// ==========================================================
	// Register decode
	wire wr_action    = WR_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_ACTION_CTRL);
	wire wr_chan_mask = WR_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_CHAN_MASK);
	wire wr_chan_flag = WR_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_CHAN_FLAGS);
	wire wr_misc_mask = WR_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_MISC_MASK);
	wire wr_misc_flag = WR_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_MISC_FLAGS);
	wire wr_acc_ctrl  = WR_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_ACC_CTRL);
	wire rd_count_hi  = RD_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_COUNT_HI);
	wire rd_count_lo  = RD_STROBE_IN && (ADDR_IN == tfp_timer_pkg::OFS_COUNT_LO);

	wire shared_sel = acc_ctrl_q[tfp_timer_pkg::ACC_SHARED_SEL];
	wire [1:0] presc_sel = misc_mask_q[tfp_timer_pkg::PRESCALE_LSB +: 2];
	wire [1:0] rate_sel  = acc_ctrl_q[tfp_timer_pkg::ACC_RATE_LSB +: 2];

	// ==========================================================
	// Prescaler and free-running count
	logic [3:0] presc_mask;
	always_comb
	begin
		unique case (presc_sel)
			2'b00: presc_mask = tfp_timer_pkg::PRESCALE_MASK_DIV1;
			2'b01: presc_mask = tfp_timer_pkg::PRESCALE_MASK_DIV4;
			2'b10: presc_mask = tfp_timer_pkg::PRESCALE_MASK_DIV8;
			2'b11: presc_mask = tfp_timer_pkg::PRESCALE_MASK_DIV16;
		endcase
	end

	wire presc_tick = ((presc_cnt_q & presc_mask) == presc_mask);
	// Count has no write path at all, so it stays read-only in every mode
	assign count_d = presc_tick ? count_q + 16'h0001 : count_q;
	wire count_rollover = presc_tick && (count_q == 16'hFFFF);

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			presc_cnt_q <= 4'h0;
			count_q     <= tfp_timer_pkg::COUNT_RESET;
			tick_q      <= 1'b0;
		end
		else
		begin
			presc_cnt_q <= presc_cnt_q + 4'h1;
			count_q     <= count_d;
			tick_q      <= presc_tick;
		end
	end

	// ==========================================================
	// Coherent two-byte read
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			low_latch_q       <= 8'h00;
			low_latch_valid_q <= 1'b0;
		end
		else
		begin
			low_latch_valid_q <= rd_count_hi;
			if (rd_count_hi)
				low_latch_q <= count_q[7:0];
		end
	end

	// ==========================================================
	// Compare match, checked on the cycle the count takes a new value
	wire [4:0] cmp_match;
	assign cmp_match[4] = tick_q && (count_q == CMP1_VALUE_IN);
	assign cmp_match[3] = tick_q && (count_q == CMP2_VALUE_IN);
	assign cmp_match[2] = tick_q && (count_q == CMP3_VALUE_IN);
	assign cmp_match[1] = tick_q && (count_q == CMP4_VALUE_IN);
	assign cmp_match[0] = tick_q && (count_q == CMP5_VALUE_IN) && !shared_sel;

	// ==========================================================
	// Compare pin actions, channels two to five
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_pin
			wire [1:0] act = action_ctrl_q[2*ch +: 2];
			assign CMP_PIN_CONNECT_OUT[ch] = (act != 2'b00) && (ch != 0 || !shared_sel);
		end
	endgenerate

	// One process drives every pin bit, so the next-value vector has a single driver
	always_comb
	begin
		pin_d = pin_q;
		for (int i = 0; i < 4; i++)
		begin
			if (cmp_match[i])
			begin
				unique case (action_ctrl_q[2*i +: 2])
					2'b00: pin_d[i] = pin_q[i];
					2'b01: pin_d[i] = !pin_q[i];
					2'b10: pin_d[i] = 1'b0;
					2'b11: pin_d[i] = 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Channel flags: set beats clear, clear by writing ones
	wire shared_event = shared_sel ? CAPTURE4_EDGE_IN : cmp_match[0];
	wire [7:0] chan_set = {cmp_match[4:1], shared_event, CAPTURE_EDGE_IN};
	wire [7:0] chan_clr = wr_chan_flag ? WR_DATA_IN : 8'h00;
	assign chan_flags_d = (chan_flags_q & ~chan_clr) | chan_set;

	// ==========================================================
	// Periodic divider, free running from reset
	logic [16:0] periodic_mask_w;
	assign periodic_mask_w = (17'h0_0001 << (PERIODIC_SHIFT + int'(rate_sel))) - 17'h0_0001;
	wire [15:0] periodic_mask = periodic_mask_w[15:0];
	wire periodic_timeout = ((periodic_div_q & periodic_mask) == periodic_mask);

	// ==========================================================
	// Misc flags
	logic [7:0] misc_set;
	always_comb
	begin
		misc_set = 8'h00;
		misc_set[tfp_timer_pkg::MISC_OVF_BIT]      = count_rollover;
		misc_set[tfp_timer_pkg::MISC_PERIODIC_BIT] = periodic_timeout;
		misc_set[tfp_timer_pkg::MISC_ACC_OVF_BIT]  = ACC_ROLLOVER_IN;
		misc_set[tfp_timer_pkg::MISC_ACC_EDGE_BIT] = ACC_EDGE_IN;
	end
	wire [7:0] misc_clr = wr_misc_flag ? WR_DATA_IN : 8'h00;
	assign misc_flags_d = ((misc_flags_q & ~misc_clr) | misc_set) & tfp_timer_pkg::MISC_FLAG_IMPL;

	// ==========================================================
	// Write-once prescaler window
	wire in_window = (cycle_cnt_q < 7'(tfp_timer_pkg::PRESCALE_WINDOW_CYCLES));
	wire presc_accept = TEST_MODE_IN || (in_window && !presc_written_q);

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			cycle_cnt_q     <= 7'h00;
			presc_written_q <= 1'b0;
		end
		else
		begin
			if (in_window)
				cycle_cnt_q <= cycle_cnt_q + 7'h01;
			if (wr_misc_mask && presc_accept)
				presc_written_q <= 1'b1;
		end
	end

	// ==========================================================
	// Control and flag registers
	wire [7:0] misc_mask_w = {WR_DATA_IN[7:4], 2'b00,
		presc_accept ? WR_DATA_IN[1:0] : misc_mask_q[1:0]};

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			action_ctrl_q  <= tfp_timer_pkg::REG_RESET;
			chan_mask_q    <= tfp_timer_pkg::REG_RESET;
			chan_flags_q   <= tfp_timer_pkg::REG_RESET;
			misc_mask_q    <= tfp_timer_pkg::REG_RESET;
			misc_flags_q   <= tfp_timer_pkg::REG_RESET;
			acc_ctrl_q     <= tfp_timer_pkg::REG_RESET;
			periodic_div_q <= 16'h0000;
			pin_q          <= 4'h0;
		end
		else
		begin
			if (wr_action)
				action_ctrl_q <= WR_DATA_IN;
			if (wr_chan_mask)
				chan_mask_q <= WR_DATA_IN;
			if (wr_misc_mask)
				misc_mask_q <= misc_mask_w & tfp_timer_pkg::MISC_MASK_IMPL;
			if (wr_acc_ctrl)
				acc_ctrl_q <= WR_DATA_IN & tfp_timer_pkg::ACC_CTRL_IMPL;
			chan_flags_q   <= chan_flags_d;
			misc_flags_q   <= misc_flags_d;
			periodic_div_q <= periodic_div_q + 16'h0001;
			pin_q          <= pin_d;
		end
	end

	// ==========================================================
	// Read data, one cycle after the strobe; unmapped reads zero
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = 8'h00;
		if (rd_count_hi)
			rd_mux = count_q[15:8];
		else if (rd_count_lo)
			rd_mux = low_latch_valid_q ? low_latch_q : count_q[7:0];
		else if (RD_STROBE_IN)
		begin
			unique case (ADDR_IN)
				tfp_timer_pkg::OFS_ACTION_CTRL: rd_mux = action_ctrl_q;
				tfp_timer_pkg::OFS_CHAN_MASK:   rd_mux = chan_mask_q;
				tfp_timer_pkg::OFS_CHAN_FLAGS:  rd_mux = chan_flags_q;
				tfp_timer_pkg::OFS_MISC_MASK:   rd_mux = misc_mask_q;
				tfp_timer_pkg::OFS_MISC_FLAGS:  rd_mux = misc_flags_q;
				tfp_timer_pkg::OFS_ACC_CTRL:    rd_mux = acc_ctrl_q;
				default:                        rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
			rd_data_q <= 8'h00;
		else
			rd_data_q <= rd_mux;
	end

	// ==========================================================
	// Outputs
	assign RD_DATA_OUT       = rd_data_q;
	assign CMP_PIN_OUT       = pin_q;
	assign SHARED_SELECT_OUT = shared_sel;
	assign COUNT_TICK_OUT    = tick_q;
	// Shared bit of the channel mask means whichever function the select picks
	assign CHANNEL_IRQ_OUT   = |(chan_mask_q & chan_flags_q);
	assign OVERFLOW_IRQ_OUT  = misc_mask_q[tfp_timer_pkg::MISC_OVF_BIT]
		&& misc_flags_q[tfp_timer_pkg::MISC_OVF_BIT];
	assign PERIODIC_IRQ_OUT  = misc_mask_q[tfp_timer_pkg::MISC_PERIODIC_BIT]
		&& misc_flags_q[tfp_timer_pkg::MISC_PERIODIC_BIT];
	assign ACC_IRQ_OUT       = |(misc_mask_q[7:4] & misc_flags_q[7:4]
		& 4'b0011);

endmodule

`default_nettype wire

/* File: test/tfp_timer_props.sv */
// Port-level assertions for the timer counter core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tfp_timer_props (
	// Clock, reset and register port
	input wire logic       CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WR_DATA_IN,
	input wire logic       WR_STROBE_IN,
	input wire logic       RD_STROBE_IN,
	input wire logic [7:0] RD_DATA_OUT,
	// Pins and requests
	input wire logic [3:0] CMP_PIN_CONNECT_OUT,
	input wire logic       SHARED_SELECT_OUT,
	input wire logic       CHANNEL_IRQ_OUT,
	input wire logic       OVERFLOW_IRQ_OUT,
	input wire logic       PERIODIC_IRQ_OUT
);
	// ==========================================================
	// Decodes
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire logic wr_mask1 = WR_STROBE_IN && ADDR_IN == 8'h03;
	wire logic wr_flag1 = WR_STROBE_IN && ADDR_IN == 8'h04;
	wire logic wr_mask2 = WR_STROBE_IN && ADDR_IN == 8'h05;
	wire logic wr_flag2 = WR_STROBE_IN && ADDR_IN == 8'h06;

	// ==========================================================
	// Properties
	property p_rd_idle; !$past(RD_STROBE_IN) |-> RD_DATA_OUT == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_flag2_low; RD_STROBE_IN && ADDR_IN == 8'h06 |=> RD_DATA_OUT[3:0] == 4'h0; endproperty
	a_flag2_low: assert property (p_flag2_low) else $error("flag low nibble not zero");
	property p_oc5_off; SHARED_SELECT_OUT |-> !CMP_PIN_CONNECT_OUT[0]; endproperty
	a_oc5_off: assert property (p_oc5_off) else $error("channel five pin driven in capture use");
	property p_chan_gate; wr_mask1 && WR_DATA_IN == 8'h00 |=> !CHANNEL_IRQ_OUT; endproperty
	a_chan_gate: assert property (p_chan_gate) else $error("channel request with mask zero");
	property p_chan_keep; wr_flag1 && WR_DATA_IN == 8'h00 && CHANNEL_IRQ_OUT |=> CHANNEL_IRQ_OUT; endproperty
	a_chan_keep: assert property (p_chan_keep) else $error("zero write cleared channel flag");
	property p_ovf_gate; wr_mask2 && !WR_DATA_IN[7] |=> !OVERFLOW_IRQ_OUT; endproperty
	a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request while disabled");
	property p_per_gate; wr_mask2 && !WR_DATA_IN[6] |=> !PERIODIC_IRQ_OUT; endproperty
	a_per_gate: assert property (p_per_gate) else $error("periodic request while disabled");
	property p_per_keep; wr_flag2 && !WR_DATA_IN[6] && PERIODIC_IRQ_OUT |=> PERIODIC_IRQ_OUT; endproperty
	a_per_keep: assert property (p_per_keep) else $error("zero write cleared periodic flag");
endmodule

bind tfp_timer_core tfp_timer_props u_props (
	.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
	.WR_STROBE_IN(WR_STROBE_IN), .RD_STROBE_IN(RD_STROBE_IN), .RD_DATA_OUT(RD_DATA_OUT),
	.CMP_PIN_CONNECT_OUT(CMP_PIN_CONNECT_OUT), .SHARED_SELECT_OUT(SHARED_SELECT_OUT),
	.CHANNEL_IRQ_OUT(CHANNEL_IRQ_OUT), .OVERFLOW_IRQ_OUT(OVERFLOW_IRQ_OUT), .PERIODIC_IRQ_OUT(PERIODIC_IRQ_OUT)
);
`default_nettype wire

/* File: test/tfp_cpu_model.sv */
// Register-port master standing in for the CPU core.
// Assumes tasks are entered right after a rising edge; no wait states.
`timescale 1ns/100ps
`default_nettype none
module tfp_cpu_model (
	// Clock and read data
	input  wire logic       clk_in,
	input  wire logic [7:0] rd_data_in,
	// Requests
	output var  logic [7:0] addr_out,
	output var  logic [7:0] wr_data_out,
	output var  logic       wr_strobe_out,
	output var  logic       rd_strobe_out
);
	initial
	begin
		{addr_out, wr_data_out, wr_strobe_out, rd_strobe_out} = 18'h0_0000;
	end
	// Flags are cleared by ones in the written byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_out <= a;
		wr_data_out <= d;
		wr_strobe_out <= 1'b1;
		@(posedge clk_in);
		wr_strobe_out <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		addr_out <= a;
		rd_strobe_out <= 1'b1;
		@(posedge clk_in);
		rd_strobe_out <= 1'b0;
		@(posedge clk_in);
		q = rd_data_in;
	endtask
	// High byte first, low byte in the very next cycle
	task automatic rd2(input logic [7:0] a1, a2, output logic [7:0] q1, q2);
		addr_out <= a1;
		rd_strobe_out <= 1'b1;
		@(posedge clk_in);
		addr_out <= a2;
		@(posedge clk_in);
		q1 = rd_data_in;
		rd_strobe_out <= 1'b0;
		@(posedge clk_in);
		q2 = rd_data_in;
	endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the timer counter core.
// Assumes the core, its package, the CPU model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} tfp_row_type;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        test_mode = 1'b0;
	logic [15:0] cmp = 16'hFFFF;
	logic [5:0]  pulse = 6'h00;
	logic [7:0]  q, q2, q3;
	wire  [7:0]  addr, wdata, rdata;
	wire  [3:0]  pin, conn;
	wire         wr, rd, sel, tick, chan_irq, ovf_irq, per_irq, acc_irq;
	wire  [2:0]  evt = {per_irq, ovf_irq, tick};
	int          fails = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n, t;
	tfp_row_type rows [13] = '{'{1'b0, 8'h02, 8'h00, 8'h00}, '{1'b0, 8'h03, 8'h00, 8'h00},
		'{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h07, 8'h00, 8'h00}, '{1'b1, 8'h05, 8'h03, 8'h03},
		'{1'b1, 8'h05, 8'hF0, 8'hF3}, '{1'b1, 8'h05, 8'h00, 8'h03}, '{1'b1, 8'h02, 8'hA5, 8'hA5},
		'{1'b1, 8'h03, 8'h5A, 8'h5A}, '{1'b1, 8'h07, 8'hFF, 8'h07}, '{1'b1, 8'h09, 8'hFF, 8'h00},
		'{1'b1, 8'h00, 8'hFF, 8'h00}, '{1'b1, 8'h03, 8'h00, 8'h00}};
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	tfp_cpu_model cpu (.clk_in(clk), .rd_data_in(rdata), .addr_out(addr), .wr_data_out(wdata),
		.wr_strobe_out(wr), .rd_strobe_out(rd));
	tfp_timer_core #(.PERIODIC_SHIFT(4)) uut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
		.WR_DATA_IN(wdata), .WR_STROBE_IN(wr), .RD_STROBE_IN(rd), .RD_DATA_OUT(rdata), .TEST_MODE_IN(test_mode),
		.CMP1_VALUE_IN(cmp), .CMP2_VALUE_IN(cmp), .CMP3_VALUE_IN(cmp), .CMP4_VALUE_IN(cmp), .CMP5_VALUE_IN(cmp),
		.CAPTURE_EDGE_IN(pulse[5:3]), .CAPTURE4_EDGE_IN(pulse[2]), .ACC_ROLLOVER_IN(pulse[1]),
		.ACC_EDGE_IN(pulse[0]), .CMP_PIN_OUT(pin), .CMP_PIN_CONNECT_OUT(conn), .SHARED_SELECT_OUT(sel),
		.COUNT_TICK_OUT(tick), .CHANNEL_IRQ_OUT(chan_irq), .OVERFLOW_IRQ_OUT(ovf_irq),
		.PERIODIC_IRQ_OUT(per_irq), .ACC_IRQ_OUT(acc_irq));

	// ==========================================================
	// Helpers
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_for(input int s, output int k);
		k = 0;
		while (evt[s] !== 1'b1)
		begin
			@(posedge clk);
			k++;
			if (k > 70000)
			begin
				fails++;
				conclude();
			end
		end
	endtask
	task automatic spacing(output int k);
		wait_for(0, k);
		@(posedge clk);
		wait_for(0, k);
		k++;
	endtask

	// ==========================================================
	// Sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i])
		begin
			if (rows[i].w)
				cpu.wr(rows[i].a, rows[i].d);
			cpu.rd(rows[i].a, q);
			chk("register row", {8'h00, rows[i].e}, {8'h00, q});
		end
		spacing(n);
		chk("tick spacing", 16'h0010, 16'(n));
		test_mode <= 1'b1;
		for (int i = 3; i >= 0; i--)
		begin
			cpu.wr(8'h05, 8'(i));
			spacing(n);
			chk("tick spacing", 16'(i == 0 ? 1 : 2 << i), 16'(n));
		end
		cpu.rd2(8'h00, 8'h01, q3, q);
		cpu.rd(8'h01, q2);
		chk("latched low byte", 16'h0003, {8'h00, 8'(q2 - q)});
		cpu.wr(8'h02, 8'h6D);
		cpu.wr(8'h07, 8'h00);
		cpu.wr(8'h03, 8'hFF);
		cpu.wr(8'h05, 8'h80);
		wait_for(1, n);
		cpu.rd(8'h00, q);
		chk("count high after wrap", 16'h0000, {8'h00, q});
		chk("pin levels", 16'h000B, {12'h000, pin});
		chk("pins driven", 16'h000F, {12'h000, conn});
		cpu.rd(8'h04, q);
		chk("channel flags", 16'h00F8, {8'h00, q});
		cpu.wr(8'h04, 8'h00);
		chk("channel request", 16'h0001, {15'h0000, chan_irq});
		cpu.wr(8'h07, 8'h04);
		chk("pins driven", 16'h000E, {12'h000, conn});
		chk("shared select", 16'h0001, {15'h0000, sel});
		cpu.wr(8'h04, 8'hFF);
		pulse <= 6'h3F;
		@(posedge clk);
		pulse <= 6'h00;
		cpu.rd(8'h04, q);
		chk("capture flags", 16'h000F, {8'h00, q});
		cpu.wr(8'h03, 8'h08);
		chk("shared enable", 16'h0001, {15'h0000, chan_irq});
		cpu.rd(8'h06, q);
		chk("misc flags", 16'h00B0, {8'h00, q & 8'hBF});
		chk("accumulator request", 16'h0000, {15'h0000, acc_irq});
		cpu.wr(8'h05, 8'h30);
		chk("accumulator request", 16'h0001, {15'h0000, acc_irq});
		cpu.wr(8'h05, 8'hC0);
		for (int r = 0; r < 4; r++)
		begin
			cpu.wr(8'h07, 8'(r));
			cpu.wr(8'h06, 8'h40);
			wait_for(2, n);
			t = cyc;
			repeat (3 * r) @(posedge clk);
			cpu.wr(8'h06, 8'h40);
			wait_for(2, n);
			chk("periodic spacing", 16'(16 << r), 16'(cyc - t));
		end
		cpu.wr(8'h06, 8'h80);
		cpu.rd(8'h06, q);
		chk("overflow cleared", 16'h0000, {8'h00, q & 8'h8F});
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t = cyc;
		cpu.wr(8'h05, 8'h40);
		wait_for(2, n);
		chk("first periodic", 16'h0001, 16'((cyc - t) inside {[16:18]}));
		cpu.rd(8'h02, q);
		chk("action after reset", 16'h0000, {8'h00, q});
		conclude();
	end
endmodule
`default_nettype wire
